/* hw/swseq_line_tick.sv */
`timescale 1ns/1ps
module swseq_line_tick import swseq_pkg::*; (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// Synchronised line reference
	input wire logic line_level_in,
	output logic tick_out
);
	typedef struct packed {
		logic last;
		logic tick;
	} swseq_tick_t;

	swseq_tick_t t_reg;
	swseq_tick_t t_next;

	// One pulse per rising zero crossing of the supply
	always_comb begin
		t_next.last = line_level_in;
		t_next.tick = line_level_in & ~t_reg.last;
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			// Same level as the synchroniser's reset: no false tick after it
			t_reg <= '{last: 1'b1, tick: 1'b0};
		end else begin
			t_reg <= t_next;
		end
	end

	assign tick_out = t_reg.tick;
endmodule // swseq_line_tick

/* hw/swseq_sync.sv */
`timescale 1ns/1ps
module swseq_sync import swseq_pkg::*; #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// Pins
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} swseq_sync_t;

	swseq_sync_t s_reg;
	swseq_sync_t s_next;

	// Open contacts read high; reset to that level
	always_comb begin
		s_next.meta = async_in;
		s_next.stable = s_reg.meta;
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			s_reg <= '1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sync_out = s_reg.stable;
endmodule // swseq_sync

/* hw/swseq_top.sv */
`timescale 1ns/1ps
module swseq_top import swseq_pkg::*; (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// Initiation contacts, low when closed to ground
	input wire logic primary_initiate_input_n_in,
	input wire logic second_initiate_input_n_in,
	input wire logic third_initiate_input_n_in,
	// Supply line reference square wave
	input wire logic line_ref_in,
	// Contactor gate
	output logic weld_gate_out,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		swseq_state_t st;
		logic [FIELD_W-1:0] cnt;
		logic [1:0] slot;
		logic gate;
		logic [7:0] seam_mode;
		logic [7:0] panel_sched;
		logic [2:0][TIME_W-1:0] tm;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} swseq_main_t;

	swseq_main_t r_reg;
	swseq_main_t r_next;

	logic [3:0] pins_sync;
	logic [2:0] init_closed;
	logic any_init;
	logic line_tick;
	logic [1:0] live_slot;
	logic [TIME_W-1:0] live_tm;
	logic [FIELD_W-1:0] weld_t;
	logic [FIELD_W-1:0] cool_t;
	logic [FIELD_W-1:0] hold_t;
	logic seam_on;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Highest-numbered closed input wins
	function automatic logic [1:0] pick_slot(input logic [2:0] closed);
		logic [1:0] s;
		s = SLOT_PANEL;
		if (closed[2]) begin
			s = SLOT_THIRD;
		end else if (closed[1]) begin
			s = SLOT_SECOND;
		end
		return s;
	endfunction

	// Interval ends on the tick that completes it; zero acts as one
	function automatic logic interval_done(input logic [FIELD_W-1:0] cnt,
			input logic [FIELD_W-1:0] lim);
		logic [FIELD_W:0] nxt;
		nxt = {1'b0, cnt} + {{FIELD_W{1'b0}}, 1'b1};
		return nxt >= {1'b0, lim};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers and line tick
	// ------------------------------------------------------------
	swseq_sync #(
		.W(4)
	) u_sync (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.async_in({line_ref_in, third_initiate_input_n_in,
			second_initiate_input_n_in, primary_initiate_input_n_in}),
		.sync_out(pins_sync)
	);

	swseq_line_tick u_tick (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.line_level_in(pins_sync[3]),
		.tick_out(line_tick)
	);

	assign init_closed = ~pins_sync[2:0];
	assign any_init = |init_closed;
	assign live_slot = pick_slot(init_closed);
	// Live selection while closed so timing changes act at once
	assign live_tm = r_reg.tm[any_init ? live_slot : r_reg.slot];
	assign weld_t = live_tm[WELD_LSB +: FIELD_W];
	assign cool_t = live_tm[COOL_LSB +: FIELD_W];
	assign hold_t = live_tm[HOLD_LSB +: FIELD_W];
	assign seam_on = (r_reg.seam_mode != SEAM_MODE_RST);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [31:0] cur;
		cur = 32'h00000000;
		r_next = r_reg;
		r_next.slot = any_init ? live_slot : r_reg.slot;
		// Moves only on line ticks, except DONE to IDLE below: gate switches in step with the line
		if (line_tick) begin
			r_next.cnt = r_reg.cnt + 8'h01;
			case (r_reg.st)
			ST_IDLE: begin
				r_next.cnt = 8'h00;
				if (any_init) begin
					r_next.st = ST_WELD;
					r_next.gate = 1'b1;
				end
			end
			ST_WELD: begin
				if (!any_init) begin
					r_next.st = ST_HOLD;
					r_next.gate = 1'b0;
					r_next.cnt = 8'h00;
				end else if (interval_done(r_reg.cnt, weld_t)) begin
					r_next.cnt = 8'h00;
					if (!seam_on) begin
						r_next.st = ST_HOLD;
						r_next.gate = 1'b0;
					end else if (cool_t != 8'h00) begin
						r_next.st = ST_COOL;
						r_next.gate = 1'b0;
					end
					// Cool of zero keeps conducting: continuous seam
				end
			end
			ST_COOL: begin
				if (interval_done(r_reg.cnt, cool_t)) begin
					r_next.cnt = 8'h00;
					if (any_init) begin
						r_next.st = ST_WELD;
						r_next.gate = 1'b1;
					end else begin
						r_next.st = ST_HOLD;
					end
				end
			end
			ST_HOLD: begin
				if (hold_t == 8'h00 || interval_done(r_reg.cnt, hold_t)) begin
					r_next.st = ST_DONE;
					r_next.cnt = 8'h00;
				end
			end
			ST_DONE: begin
				r_next.cnt = 8'h00;
			end
			default: begin
				r_next.st = ST_IDLE;
				r_next.gate = 1'b0;
			end
			endcase
		end
		// Needs every contact open before a new sequence may start
		if (r_reg.st == ST_DONE && !any_init) begin
			r_next.st = ST_IDLE;
		end
		// --- AXI write: address and data in either order
		if (s_axi_awvalid && !r_reg.aw_got && !r_reg.bvalid) begin
			r_next.aw_got = 1'b1;
			r_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !r_reg.w_got && !r_reg.bvalid) begin
			r_next.w_got = 1'b1;
			r_next.wdata = s_axi_wdata;
			r_next.wstrb = s_axi_wstrb;
		end
		if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
			r_next.aw_got = 1'b0;
			r_next.w_got = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = RESP_OKAY;
			if (r_reg.awaddr == REG_CTRL) begin
				cur = merge({24'h000000, r_reg.seam_mode}, r_reg.wdata,
					r_reg.wstrb);
				r_next.seam_mode = cur[7:0];
			end else if (r_reg.awaddr == REG_PANEL) begin
				cur = merge({24'h000000, r_reg.panel_sched}, r_reg.wdata,
					r_reg.wstrb);
				r_next.panel_sched = cur[7:0];
			end else if (r_reg.awaddr == REG_TIME_PANEL) begin
				cur = merge({8'h00, r_reg.tm[0]}, r_reg.wdata, r_reg.wstrb);
				r_next.tm[0] = cur[TIME_W-1:0];
			end else if (r_reg.awaddr == REG_TIME_SEC) begin
				cur = merge({8'h00, r_reg.tm[1]}, r_reg.wdata, r_reg.wstrb);
				r_next.tm[1] = cur[TIME_W-1:0];
			end else if (r_reg.awaddr == REG_TIME_THIRD) begin
				cur = merge({8'h00, r_reg.tm[2]}, r_reg.wdata, r_reg.wstrb);
				r_next.tm[2] = cur[TIME_W-1:0];
			end else if (r_reg.awaddr != REG_STATUS) begin
				r_next.bresp = RESP_SLVERR;
			end
		end
		if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end

		// --- AXI read
		if (s_axi_arvalid && !r_reg.rvalid) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = RESP_OKAY;
			r_next.rdata = 32'h00000000;
			if (s_axi_araddr == REG_CTRL) begin
				r_next.rdata[7:0] = r_reg.seam_mode;
			end else if (s_axi_araddr == REG_STATUS) begin
				r_next.rdata[STATUS_STATE_LSB +: 3] = r_reg.st;
				r_next.rdata[STATUS_GATE_BIT] = r_reg.gate;
				r_next.rdata[STATUS_SCHED_LSB +: 8] =
					(r_reg.slot == SLOT_THIRD) ? SCHED_THIRD :
					(r_reg.slot == SLOT_SECOND) ? SCHED_SECOND :
					r_reg.panel_sched;
				r_next.rdata[STATUS_CNT_LSB +: FIELD_W] = r_reg.cnt;
			end else if (s_axi_araddr == REG_PANEL) begin
				r_next.rdata[7:0] = r_reg.panel_sched;
			end else if (s_axi_araddr == REG_TIME_PANEL) begin
				r_next.rdata[TIME_W-1:0] = r_reg.tm[0];
			end else if (s_axi_araddr == REG_TIME_SEC) begin
				r_next.rdata[TIME_W-1:0] = r_reg.tm[1];
			end else if (s_axi_araddr == REG_TIME_THIRD) begin
				r_next.rdata[TIME_W-1:0] = r_reg.tm[2];
			end else begin
				r_next.rresp = RESP_SLVERR;
			end
		end
		if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			r_reg <= '0;
			r_reg.st <= ST_IDLE;
			r_reg.seam_mode <= SEAM_MODE_RST;
			r_reg.panel_sched <= PANEL_RST;
			r_reg.tm <= {TIME_RST, TIME_RST, TIME_RST};
		end else begin
			r_reg <= r_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign weld_gate_out = r_reg.gate;
	assign s_axi_awready = !r_reg.aw_got && !r_reg.bvalid;
	assign s_axi_wready = !r_reg.w_got && !r_reg.bvalid;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_arready = !r_reg.rvalid;
	assign s_axi_rvalid = r_reg.rvalid;
	assign s_axi_rdata = r_reg.rdata;
	assign s_axi_rresp = r_reg.rresp;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	sequence s_weld_tick;
		r_reg.st == ST_WELD && line_tick;
	endsequence
	sequence s_cool_tick;
		r_reg.st == ST_COOL && line_tick;
	endsequence

	AST_SPOT_NO_COOL: assert property (
		!seam_on && r_reg.st != ST_COOL |=> r_reg.st != ST_COOL)
		else $error("cool entered in spot mode");
	AST_GATE_ON_TICK: assert property (
		$changed(r_reg.gate) |-> $past(line_tick))
		else $error("gate changed off a line boundary");
	AST_WELD_TO_COOL: assert property (
		s_weld_tick ##0 (any_init && seam_on && cool_t != 8'h00
		&& interval_done(r_reg.cnt, weld_t))
		|=> r_reg.st == ST_COOL && !r_reg.gate && r_reg.cnt == 8'h00)
		else $error("weld impulse did not end into cool");
	AST_COOL_REPEAT: assert property (
		s_cool_tick ##0 (any_init && interval_done(r_reg.cnt, cool_t))
		|=> r_reg.st == ST_WELD && r_reg.gate)
		else $error("impulse did not repeat after cool");
	AST_OPEN_IN_WELD: assert property (
		s_weld_tick ##0 !any_init |=> r_reg.st == ST_HOLD && !r_reg.gate)
		else $error("open during weld did not enter hold");
	AST_COOL_FULL: assert property (
		s_cool_tick ##0 !interval_done(r_reg.cnt, cool_t)
		|=> r_reg.st == ST_COOL)
		else $error("cool interval cut short");
	AST_CONTINUOUS: assert property (
		s_weld_tick ##0 (any_init && seam_on && cool_t == 8'h00)
		|=> r_reg.st == ST_WELD && r_reg.gate)
		else $error("continuous seam current broke");
	AST_SLOT_FOLLOW: assert property (
		any_init |=> r_reg.slot == ($past(init_closed[2]) ? SLOT_THIRD :
		$past(init_closed[1]) ? SLOT_SECOND : SLOT_PANEL))
		else $error("active schedule not the highest closed input");
	AST_TICK_ONLY: assert property (
		!line_tick && r_reg.st != ST_DONE |=> $stable(r_reg.st))
		else $error("sequence moved between line cycles");
	AST_IDLE_RETURN: assert property (
		r_reg.st == ST_DONE && !any_init |=> r_reg.st == ST_IDLE
		&& !r_reg.gate)
		else $error("no return to idle after hold");
endmodule // swseq_top

/* pkg/swseq_pkg.sv */
package swseq_pkg;
	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PANEL = 8'h08;
	localparam logic [7:0] REG_TIME_PANEL = 8'h10;
	localparam logic [7:0] REG_TIME_SEC = 8'h14;
	localparam logic [7:0] REG_TIME_THIRD = 8'h18;
	localparam int ADDR_W = 8;

	// ------------------------------------------------------------
	// Field layout of the timing registers (in line cycles) and status register
	// ------------------------------------------------------------
	localparam int FIELD_W = 8;
	localparam int WELD_LSB = 0;
	localparam int COOL_LSB = 8;
	localparam int HOLD_LSB = 16;
	localparam int TIME_W = 24;
	localparam int STATUS_STATE_LSB = 0;
	localparam int STATUS_GATE_BIT = 4;
	localparam int STATUS_SCHED_LSB = 8;
	localparam int STATUS_CNT_LSB = 16;

	// ------------------------------------------------------------
	// Reset values and fixed schedule numbers
	// ------------------------------------------------------------
	localparam logic [7:0] SEAM_MODE_RST = 8'h00;
	localparam logic [7:0] PANEL_RST = 8'h00;
	localparam logic [TIME_W-1:0] TIME_RST = 24'h000000;
	localparam logic [7:0] SCHED_SECOND = 8'h0a;
	localparam logic [7:0] SCHED_THIRD = 8'h14;
	localparam logic [1:0] SLOT_PANEL = 2'h0;
	localparam logic [1:0] SLOT_SECOND = 2'h1;
	localparam logic [1:0] SLOT_THIRD = 2'h2;

	// ------------------------------------------------------------
	// AXI responses
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WELD = 3'b001,
		ST_COOL = 3'b010,
		ST_HOLD = 3'b011,
		ST_DONE = 3'b100
	} swseq_state_t;
endpackage

/* test/swseq_partner.sv */
`timescale 1ns/1ps
// ------------------------------------------
// Initiation contacts, line, contactor watch
// ------------------------------------------
module swseq_partner (
	// Clock
	input wire logic mclk_in,
	// Commands from the bench and contactor gate
	input wire logic [2:0] close_in,
	input wire logic gate_in,
	// Pins
	output logic line_ref_out = 1'b0,
	output logic [2:0] pin_n_out = 3'h7,
	// Gate run lengths in line cycles, and count of gate-on runs
	output logic [7:0] on_len_out = 8'h00,
	output logic [7:0] off_len_out = 8'h00,
	output logic [7:0] runs_out = 8'h00
);
	logic [4:0] ph = 5'h00;
	logic [7:0] len = 8'h00;
	logic last = 1'b0;

	// Short line period keeps the run brief; the sequencer only counts edges
	always_ff @(posedge mclk_in) begin
		pin_n_out <= ~close_in;
		ph <= (ph == 5'h13) ? 5'h00 : ph + 5'h01;
		line_ref_out <= (ph < 5'h0a);
		// Gate sampled once a line cycle, just before the new cycle starts
		if (ph == 5'h00) begin
			if (gate_in == last) begin
				len <= len + 8'h01;
			end else begin
				len <= 8'h01;
				last <= gate_in;
				if (last)
					on_len_out <= len;
				else
					off_len_out <= len;
				if (gate_in)
					runs_out <= runs_out + 8'h01;
			end
		end
	end
endmodule // swseq_partner

/* test/test_seam_weld_sequencer.sv */
`timescale 1ns/1ps
module test_seam_weld_sequencer import swseq_pkg::*;;
	logic mclk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [2:0] close_cmd = 3'h0;
	logic [2:0] pin_n;
	logic line_ref, gate;
	logic [7:0] on_len, off_len, runs, r0;
	logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, data;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	int failures = 0, samples_checked = 0, cycles = 0;

	always #25 mclk_in = ~mclk_in;

	swseq_partner i_partner (.mclk_in(mclk_in), .close_in(close_cmd),
		.gate_in(gate), .line_ref_out(line_ref), .pin_n_out(pin_n),
		.on_len_out(on_len), .off_len_out(off_len), .runs_out(runs));

	swseq_top i_dut (.mclk_in(mclk_in), .srst_in(srst_in),
		.primary_initiate_input_n_in(pin_n[0]),
		.second_initiate_input_n_in(pin_n[1]),
		.third_initiate_input_n_in(pin_n[2]),
		.line_ref_in(line_ref), .weld_gate_out(gate),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// ------------------------------------------
	// Reporting
	// ------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	// ------------------------------------------
	// Bus and timing helpers
	// ------------------------------------------
	// Handshakes judged at the falling edge, acted on at the next rise
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic hs_aw, hs_w, hs_b;
		hs_b = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!hs_b) begin
			@(negedge mclk_in);
			hs_aw = awvalid && awready;
			hs_w = wvalid && wready;
			hs_b = bvalid && bready;
			resp = bresp;
			@(posedge mclk_in);
			if (hs_aw)
				awvalid <= 1'b0;
			if (hs_w)
				wvalid <= 1'b0;
			if (hs_b)
				bready <= 1'b0;
		end
		@(posedge mclk_in);
	endtask

	task automatic rd(input logic [7:0] a);
		logic hs_ar, hs_r;
		hs_r = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!hs_r) begin
			@(negedge mclk_in);
			hs_ar = arvalid && arready;
			hs_r = rvalid && rready;
			data = rdata;
			resp = rresp;
			@(posedge mclk_in);
			if (hs_ar)
				arvalid <= 1'b0;
			if (hs_r)
				rready <= 1'b0;
		end
		@(posedge mclk_in);
	endtask

	task automatic lines(input int n);
		repeat (n) @(posedge line_ref);
		repeat (10) @(posedge mclk_in);
	endtask

	task automatic gate_is(input logic v);
		while (gate !== v) @(negedge mclk_in);
		@(posedge mclk_in);
	endtask

	// ------------------------------------------
	// Scenarios
	// ------------------------------------------
	task automatic t_regs;
		logic [7:0] regs [5] = '{REG_CTRL, REG_PANEL, REG_TIME_PANEL,
			REG_TIME_SEC, REG_TIME_THIRD};
		for (int i = 0; i < 5; i++) begin
			rd(regs[i]);
			check("reset value", data, 32'h0);
		end
		rd(8'h0c);
		check("unmapped rresp", resp, RESP_SLVERR);
		check("unmapped rdata", data, 32'h0);
		wr(8'h0c, 32'h1);
		check("unmapped bresp", resp, RESP_SLVERR);
		// Unused upper byte of a timing word reads zero
		wr(REG_TIME_SEC, 32'hffffffff);
		rd(REG_TIME_SEC);
		check("timing width", data, 32'h00ffffff);
		wr(REG_STATUS, 32'hffffffff);
		check("status write bresp", resp, RESP_OKAY);
		rd(REG_STATUS);
		check("status untouched", data[4:0], 32'h0);
	endtask

	task automatic t_spot;
		wr(REG_CTRL, 32'h0);
		wr(REG_TIME_PANEL, 32'h00010003);
		close_cmd <= 3'h1;
		lines(8);
		check("spot weld cycles", on_len, 8'h03);
		rd(REG_STATUS);
		check("spot waits for open", data[2:0], ST_DONE);
		close_cmd <= 3'h0;
		lines(1);
		rd(REG_STATUS);
		check("back to idle", data[4:0], ST_IDLE);
	endtask

	task automatic t_inter;
		wr(REG_CTRL, 32'h1);
		wr(REG_TIME_PANEL, 32'h00010302);
		r0 = runs;
		close_cmd <= 3'h1;
		lines(12);
		check("impulse on", on_len, 8'h02);
		check("impulse off", off_len, 8'h03);
		check("impulses repeat", runs - r0 > 8'h02, 32'h1);
		// Catch the start of an impulse, not the middle of one
		gate_is(1'b0);
		gate_is(1'b1);
		close_cmd <= 3'h0;
		lines(2);
		check("weld cut short", on_len, 8'h01);
		lines(3);
		rd(REG_STATUS);
		check("ended", data[4:0], ST_IDLE);
		close_cmd <= 3'h1;
		gate_is(1'b1);
		gate_is(1'b0);
		close_cmd <= 3'h0;
		r0 = runs;
		lines(1);
		rd(REG_STATUS);
		check("cool runs out", data[2:0], ST_COOL);
		lines(6);
		check("no new impulse", runs, r0);
		rd(REG_STATUS);
		check("idle after cool", data[2:0], ST_IDLE);
	endtask

	task automatic t_cont;
		wr(REG_TIME_PANEL, 32'h00000001);
		r0 = runs;
		close_cmd <= 3'h1;
		lines(10);
		check("continuous gate", gate, 1'b1);
		check("single run", runs - r0, 32'h1);
		close_cmd <= 3'h0;
		lines(1);
		check("stop on open", gate, 1'b0);
		lines(1);
		check("long run", on_len > 8'h08, 32'h1);
		lines(2);
	endtask

	task automatic t_sched;
		wr(REG_PANEL, 32'h7);
		wr(REG_TIME_PANEL, 32'h00000108);
		wr(REG_TIME_SEC, 32'h00000101);
		wr(REG_TIME_THIRD, 32'h00000101);
		close_cmd <= 3'h1;
		gate_is(1'b1);
		close_cmd <= 3'h3;
		rd(REG_STATUS);
		check("panel schedule", data[15:8], 8'h07);
		gate_is(1'b0);
		lines(1);
		check("switch mid weld", on_len < 8'h04, 32'h1);
		rd(REG_STATUS);
		check("second", data[15:8], SCHED_SECOND);
		close_cmd <= 3'h7;
		lines(1);
		rd(REG_STATUS);
		check("third", data[15:8], SCHED_THIRD);
		close_cmd <= 3'h3;
		lines(1);
		rd(REG_STATUS);
		check("back to second", data[15:8], SCHED_SECOND);
		close_cmd <= 3'h0;
		lines(4);
	endtask

	initial begin
		repeat (16) @(posedge mclk_in);
		srst_in <= 1'b0;
		@(posedge mclk_in);
		t_regs();
		t_spot();
		t_inter();
		t_cont();
		t_sched();
		print_verdict();
	end
endmodule // test_seam_weld_sequencer
